// file: rtl/scrb_defs.svh
`ifndef SCRB_DEFS_SVH
`define SCRB_DEFS_SVH

// Register numbers
`define SCRB_RUN_AND_INPUT_COMMAND    16'h0001
`define SCRB_SPEED_SETPOINT           16'h0002
`define SCRB_VOLTS_PER_HERTZ_GAIN     16'h0003
`define SCRB_LOOP_SETPOINT            16'h0006
`define SCRB_ANALOG_OUT_ONE_LEVEL     16'h0007
`define SCRB_ANALOG_OUT_TWO_LEVEL     16'h0008
`define SCRB_DIGITAL_OUTPUT_OVERRIDE  16'h0009
`define SCRB_PULSE_OUT_FREQUENCY      16'h000a
`define SCRB_SOURCE_SELECTION         16'h000f
`define SCRB_MONITOR_BASE             16'h0020
`define SCRB_MONITOR_LAST             16'h003f

// Run and input command fields
`define SCRB_RUN_BIT0                 0
`define SCRB_RUN_BIT1                 1
`define SCRB_EXT_FAULT_BIT            2
`define SCRB_FAULT_RESET_BIT          3
`define SCRB_VIN1_BIT                 4
`define SCRB_VIN2_BIT                 5
`define SCRB_VIN3_LSB                 6
`define SCRB_RUN_CMD_MASK             16'h07ff

// Digital override fields
`define SCRB_RELAY_BIT                0
`define SCRB_OPTO1_BIT                1
`define SCRB_OPTO2_BIT                2
`define SCRB_FAULT_EN_BIT             6
`define SCRB_FAULT_CONTACT_BIT        7
`define SCRB_DOUT_MASK                16'h00c7

// Source selection fields
`define SCRB_PID_SEL_BIT              1
`define SCRB_BCAST_S5_BIT             12
`define SCRB_SRC_SEL_MASK             16'h7002

// Function codes and limits
`define SCRB_FUNC_SERIAL_REF          8'h28
`define SCRB_FUNC_SERIAL_CTRL         8'h2a
`define SCRB_PULSE_MAX                16'h7d00
`define SCRB_RESET_WORD               16'h0000

`endif

// file: rtl/scrb_pkg.sv
package scrb_pkg;
    typedef enum logic [1:0] {
        SCRB_CLASS_COMMAND   = 2'b00,
        SCRB_CLASS_MONITOR   = 2'b01,
        SCRB_CLASS_BROADCAST = 2'b10,
        SCRB_CLASS_NONE      = 2'b11
    } scrb_class_t;

    typedef enum logic [1:0] {
        SCRB_ACC_IDLE   = 2'b00,
        SCRB_ACC_ACCEPT = 2'b01,
        SCRB_ACC_REJECT = 2'b10
    } scrb_acc_t;
endpackage

// file: rtl/scrb_class_decode.sv
`timescale 1ns/1ps
`include "scrb_defs.svh"

module scrb_class_decode (
    input  wire logic [15:0]          i_addr,
    output scrb_pkg::scrb_class_t     o_class
);
    always_comb begin
        if (i_addr < `SCRB_MONITOR_BASE) begin
            o_class = scrb_pkg::SCRB_CLASS_COMMAND;
        end else if (i_addr <= `SCRB_MONITOR_LAST) begin
            o_class = scrb_pkg::SCRB_CLASS_MONITOR;
        end else begin
            o_class = scrb_pkg::SCRB_CLASS_BROADCAST;
        end
    end
endmodule

// file: rtl/scrb_run_decode.sv
`timescale 1ns/1ps
`include "scrb_defs.svh"

module scrb_run_decode (
    input  wire logic        i_run_method_select,
    input  wire logic [1:0]  i_run_bits,
    output logic             o_fwd_run,
    output logic             o_rev_run
);
    always_comb begin
        if (i_run_method_select) begin
            // Bit 0 is run/stop, bit 1 picks reverse
            o_fwd_run = i_run_bits[0] & ~i_run_bits[1];
            o_rev_run = i_run_bits[0] & i_run_bits[1];
        end else begin
            // Both set is passed as is; the motor logic resolves it
            o_fwd_run = i_run_bits[0];
            o_rev_run = i_run_bits[1];
        end
    end
endmodule

// file: rtl/scrb_bank.sv
// Behaviour
// [R1] Every command register is readable and writable; reads return the last write.
// [R2] Register space splits into command, monitor and broadcast classes.
// [R3] Master writes zero in unused bits and avoids reserved registers.
// [R4] Run method 0: bit 0 forward run, bit 1 reverse run.
// [R5] Run method 1: bit 0 run/stop, bit 1 selects reverse.
// [R6] Bit 2 external fault, bit 3 fault reset, bits 6-A virtual inputs 3-7.
// [R7] Bit 4 is virtual input 1, or serial reference select when function is 40.
// [R8] Bit 5 is virtual input 2, or serial control select when function is 42.
// [R9] Speed setpoint is scaled per the display unit setting.
// [R10] Loop setpoint is signed, 0.01 percent per count.
// [R11] Analog out words set outputs one and two; 4000h is 10 V.
// [R12] Override bits 0-2 drive relay and both optocoupler outputs.
// [R13] Fault contact follows bit 7 only while bit 6 enables it.
// [R14] Pulse output frequency accepted only in 0 to 32000 Hz.
// [R15] Source selection: bit 1 PID input, bits C-E broadcast terminals 5-7.
// [R16] Writes to monitor registers are rejected.
// [R17] Each register is one 16-bit word, bit 0 least significant.
`timescale 1ns/1ps
`include "scrb_defs.svh"

module scrb_bank (
    input  wire logic          i_clk,
    input  wire logic          i_sys_rst,
    input  wire logic          i_wr_en,
    input  wire logic          i_rd_en,
    input  wire logic [15:0]   i_addr,
    input  wire logic [15:0]   i_wdata,
    output logic [15:0]        o_rdata,
    output logic               o_rd_valid,
    output logic               o_ack,
    output logic               o_err,
    output logic               o_monitor_rd,
    output logic               o_broadcast_rd,
    input  wire logic          i_run_method_select,
    input  wire logic [7:0]    i_input_one_function,
    input  wire logic [7:0]    i_input_two_function,
    input  wire logic [1:0]    i_display_unit,
    output logic               o_fwd_run,
    output logic               o_rev_run,
    output logic               o_serial_external_fault,
    output logic               o_fault_reset,
    output logic [6:0]         o_virtual_inputs,
    output logic               o_serial_reference_select,
    output logic               o_serial_control_select,
    output logic [15:0]        o_speed_setpoint,
    output logic [1:0]         o_speed_units,
    output logic [15:0]        o_vf_gain,
    output logic signed [15:0] o_loop_setpoint,
    output logic [15:0]        o_analog_out_one,
    output logic [15:0]        o_analog_out_two,
    output logic               o_relay_contact_terminals,
    output logic               o_optocoupler_out_one,
    output logic               o_optocoupler_out_two,
    output logic               o_fault_contact_override,
    output logic               o_fault_contact_level,
    output logic [15:0]        o_pulse_train_out,
    output logic               o_pid_serial_select,
    output logic               o_input_terminal_five,
    output logic               o_input_terminal_six,
    output logic               o_input_terminal_seven
);
    logic [15:0] run_q;
    logic [15:0] speed_q;
    logic [15:0] gain_q;
    logic [15:0] loop_q;
    logic [15:0] aout1_q;
    logic [15:0] aout2_q;
    logic [15:0] dout_q;
    logic [15:0] pulse_q;
    logic [15:0] srcsel_q;
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic        rd_valid_q;
    logic        fwd_d;
    logic        rev_d;
    logic        is_cmd;
    logic        is_mapped;
    logic        wr_ok;
    logic        pulse_ok;
    scrb_pkg::scrb_class_t acc_class;
    scrb_pkg::scrb_acc_t   acc_q;

    scrb_class_decode u_class (
        .i_addr  (i_addr),
        .o_class (acc_class)
    );

    assign is_cmd = (acc_class == scrb_pkg::SCRB_CLASS_COMMAND); // see [R2]

    always_comb begin
        case (i_addr)
            `SCRB_RUN_AND_INPUT_COMMAND,
            `SCRB_SPEED_SETPOINT,
            `SCRB_VOLTS_PER_HERTZ_GAIN,
            `SCRB_LOOP_SETPOINT,
            `SCRB_ANALOG_OUT_ONE_LEVEL,
            `SCRB_ANALOG_OUT_TWO_LEVEL,
            `SCRB_DIGITAL_OUTPUT_OVERRIDE,
            `SCRB_PULSE_OUT_FREQUENCY,
            `SCRB_SOURCE_SELECTION: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    end

    assign pulse_ok = (i_wdata <= `SCRB_PULSE_MAX); // see [R14]
    // Reserved words and monitor space never store; out of range pulse values also refused
    assign wr_ok    = i_wr_en && is_cmd && is_mapped &&
                      ((i_addr != `SCRB_PULSE_OUT_FREQUENCY) || pulse_ok); // see [R16]

    // Unused bits are masked so reads never show stray writes from a careless master
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            run_q    <= `SCRB_RESET_WORD;
            speed_q  <= `SCRB_RESET_WORD;
            gain_q   <= `SCRB_RESET_WORD;
            loop_q   <= `SCRB_RESET_WORD;
            aout1_q  <= `SCRB_RESET_WORD;
            aout2_q  <= `SCRB_RESET_WORD;
            dout_q   <= `SCRB_RESET_WORD;
            pulse_q  <= `SCRB_RESET_WORD;
            srcsel_q <= `SCRB_RESET_WORD;
        end else if (wr_ok) begin
            case (i_addr)
                `SCRB_RUN_AND_INPUT_COMMAND:   run_q    <= i_wdata & `SCRB_RUN_CMD_MASK; // see [R1] see [R3]
                `SCRB_SPEED_SETPOINT:          speed_q  <= i_wdata; // see [R9]
                `SCRB_VOLTS_PER_HERTZ_GAIN:    gain_q   <= i_wdata;
                `SCRB_LOOP_SETPOINT:           loop_q   <= i_wdata; // see [R10]
                `SCRB_ANALOG_OUT_ONE_LEVEL:    aout1_q  <= i_wdata; // see [R11]
                `SCRB_ANALOG_OUT_TWO_LEVEL:    aout2_q  <= i_wdata; // see [R11]
                `SCRB_DIGITAL_OUTPUT_OVERRIDE: dout_q   <= i_wdata & `SCRB_DOUT_MASK;
                `SCRB_PULSE_OUT_FREQUENCY:     pulse_q  <= i_wdata; // see [R14]
                `SCRB_SOURCE_SELECTION:        srcsel_q <= i_wdata & `SCRB_SRC_SEL_MASK;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (i_addr)
            `SCRB_RUN_AND_INPUT_COMMAND:   rdata_d = run_q; // see [R1] see [R17]
            `SCRB_SPEED_SETPOINT:          rdata_d = speed_q;
            `SCRB_VOLTS_PER_HERTZ_GAIN:    rdata_d = gain_q;
            `SCRB_LOOP_SETPOINT:           rdata_d = loop_q;
            `SCRB_ANALOG_OUT_ONE_LEVEL:    rdata_d = aout1_q;
            `SCRB_ANALOG_OUT_TWO_LEVEL:    rdata_d = aout2_q;
            `SCRB_DIGITAL_OUTPUT_OVERRIDE: rdata_d = dout_q;
            `SCRB_PULSE_OUT_FREQUENCY:     rdata_d = pulse_q;
            `SCRB_SOURCE_SELECTION:        rdata_d = srcsel_q;
            default:                       rdata_d = `SCRB_RESET_WORD;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_q    <= `SCRB_RESET_WORD;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= i_rd_en && !i_wr_en;
            if (i_rd_en && !i_wr_en) begin
                rdata_q <= rdata_d;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            acc_q <= scrb_pkg::SCRB_ACC_IDLE;
        end else if (i_wr_en) begin
            acc_q <= wr_ok ? scrb_pkg::SCRB_ACC_ACCEPT : scrb_pkg::SCRB_ACC_REJECT; // see [R16]
        end else if (i_rd_en) begin
            acc_q <= scrb_pkg::SCRB_ACC_ACCEPT;
        end else begin
            acc_q <= scrb_pkg::SCRB_ACC_IDLE;
        end
    end

    assign o_rdata        = rdata_q;
    assign o_rd_valid     = rd_valid_q;
    assign o_ack          = (acc_q == scrb_pkg::SCRB_ACC_ACCEPT);
    assign o_err          = (acc_q == scrb_pkg::SCRB_ACC_REJECT);
    // Monitor and broadcast reads are served elsewhere; flag them to that logic
    assign o_monitor_rd   = i_rd_en && (acc_class == scrb_pkg::SCRB_CLASS_MONITOR); // see [R2]
    assign o_broadcast_rd = i_rd_en && (acc_class == scrb_pkg::SCRB_CLASS_BROADCAST); // see [R2]

    scrb_run_decode u_run (
        .i_run_method_select (i_run_method_select),
        .i_run_bits          (run_q[`SCRB_RUN_BIT1:`SCRB_RUN_BIT0]),
        .o_fwd_run           (fwd_d),
        .o_rev_run           (rev_d)
    ); // see [R4] see [R5]

    // Decoded controls registered so the motor side sees clean levels
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_fwd_run                 <= 1'b0;
            o_rev_run                 <= 1'b0;
            o_serial_external_fault   <= 1'b0;
            o_fault_reset             <= 1'b0;
            o_virtual_inputs          <= 7'h00;
            o_serial_reference_select <= 1'b0;
            o_serial_control_select   <= 1'b0;
        end else begin
            o_fwd_run               <= fwd_d; // see [R4] see [R5]
            o_rev_run               <= rev_d;
            o_serial_external_fault <= run_q[`SCRB_EXT_FAULT_BIT]; // see [R6]
            o_fault_reset           <= run_q[`SCRB_FAULT_RESET_BIT]; // see [R6]
            o_virtual_inputs[6:2]   <= run_q[`SCRB_VIN3_LSB +: 5]; // see [R6]
            if (i_input_one_function == `SCRB_FUNC_SERIAL_REF) begin
                o_serial_reference_select <= run_q[`SCRB_VIN1_BIT]; // see [R7]
                o_virtual_inputs[0]       <= 1'b0;
            end else begin
                o_serial_reference_select <= 1'b0;
                o_virtual_inputs[0]       <= run_q[`SCRB_VIN1_BIT]; // see [R7]
            end
            if (i_input_two_function == `SCRB_FUNC_SERIAL_CTRL) begin
                o_serial_control_select <= run_q[`SCRB_VIN2_BIT]; // see [R8]
                o_virtual_inputs[1]     <= 1'b0;
            end else begin
                o_serial_control_select <= 1'b0;
                o_virtual_inputs[1]     <= run_q[`SCRB_VIN2_BIT]; // see [R8]
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_relay_contact_terminals <= 1'b0;
            o_optocoupler_out_one     <= 1'b0;
            o_optocoupler_out_two     <= 1'b0;
            o_fault_contact_override  <= 1'b0;
            o_fault_contact_level     <= 1'b0;
            o_pid_serial_select       <= 1'b0;
            o_input_terminal_five     <= 1'b0;
            o_input_terminal_six      <= 1'b0;
            o_input_terminal_seven    <= 1'b0;
        end else begin
            o_relay_contact_terminals <= dout_q[`SCRB_RELAY_BIT]; // see [R12]
            o_optocoupler_out_one     <= dout_q[`SCRB_OPTO1_BIT]; // see [R12]
            o_optocoupler_out_two     <= dout_q[`SCRB_OPTO2_BIT]; // see [R12]
            o_fault_contact_override  <= dout_q[`SCRB_FAULT_EN_BIT]; // see [R13]
            o_fault_contact_level     <= dout_q[`SCRB_FAULT_EN_BIT] & dout_q[`SCRB_FAULT_CONTACT_BIT]; // see [R13]
            o_pid_serial_select       <= srcsel_q[`SCRB_PID_SEL_BIT]; // see [R15]
            o_input_terminal_five     <= srcsel_q[`SCRB_BCAST_S5_BIT]; // see [R15]
            o_input_terminal_six      <= srcsel_q[`SCRB_BCAST_S5_BIT + 1];
            o_input_terminal_seven    <= srcsel_q[`SCRB_BCAST_S5_BIT + 2];
        end
    end

    assign o_speed_setpoint = speed_q; // see [R9]
    assign o_speed_units    = i_display_unit;
    assign o_vf_gain        = gain_q;
    assign o_loop_setpoint  = $signed(loop_q); // see [R10]
    assign o_analog_out_one = aout1_q;
    assign o_analog_out_two = aout2_q;
    assign o_pulse_train_out = pulse_q;

    AST_READBACK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_ok && i_addr == `SCRB_LOOP_SETPOINT) ##1 (i_rd_en && !i_wr_en && i_addr == `SCRB_LOOP_SETPOINT)
        |=> (o_rdata == $past(i_wdata, 2)) && o_rd_valid)
        else $error("Readback differs from last write"); // see [R1]
    AST_MONITOR_REJECT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr >= `SCRB_MONITOR_BASE) |=> (o_err && !o_ack))
        else $error("Monitor write not rejected"); // see [R16]
    AST_PULSE_RANGE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr == `SCRB_PULSE_OUT_FREQUENCY && i_wdata > `SCRB_PULSE_MAX)
        |=> ($stable(pulse_q) && o_err))
        else $error("Out of range pulse value stored"); // see [R14]
    AST_FWD_M0: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!i_run_method_select && run_q[0]) |=> o_fwd_run)
        else $error("Forward run missing in method 0"); // see [R4]
    AST_REV_M1: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_run_method_select && run_q[1:0] == 2'b10) |=> (!o_rev_run && !o_fwd_run))
        else $error("Direction without run in method 1"); // see [R5]
    AST_EXT_FAULT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        1'b1 |=> (o_serial_external_fault == $past(run_q[2]) && o_virtual_inputs[6] == $past(run_q[10])))
        else $error("Fault or input bit mismatch"); // see [R6]
    AST_SERIAL_REF: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_input_one_function == 8'h28 && run_q[4]) |=> (o_serial_reference_select && !o_virtual_inputs[0]))
        else $error("Serial reference select not taken"); // see [R7]
    AST_SERIAL_CTRL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_input_two_function != 8'h2a) |=> !o_serial_control_select)
        else $error("Serial control select without function 42"); // see [R8]
    AST_FAULT_CONTACT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!dout_q[6]) |=> !o_fault_contact_level)
        else $error("Fault contact driven while disabled"); // see [R13]
    AST_RELAY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_ok && i_addr == `SCRB_DIGITAL_OUTPUT_OVERRIDE) |-> ##2 (o_relay_contact_terminals == $past(i_wdata[0], 2)))
        else $error("Relay output not following write"); // see [R12]
    AST_SRC_SEL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        1'b1 |=> (o_input_terminal_seven == $past(srcsel_q[14]) && o_pid_serial_select == $past(srcsel_q[1])))
        else $error("Source selection bit mismatch"); // see [R15]
endmodule

// file: tb/scrb_master_model.sv
`timescale 1ns/1ps
module scrb_master_model (
    input  wire logic        i_clk,
    output logic             o_wr_en,
    output logic             o_rd_en,
    output logic [15:0]      o_addr,
    output logic [15:0]      o_wdata,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_rd_valid,
    input  wire logic        i_ack,
    input  wire logic        i_err,
    input  wire logic        i_monitor_rd,
    input  wire logic        i_broadcast_rd
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = 16'h5555;
        o_wdata = 16'haaaa;
    end

    // Idle lines flip to the inverse, so a stale value never looks valid
    task automatic release_bus();
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = ~o_addr;
        o_wdata = ~o_wdata;
    endtask

    // One whole word per request; reserved targets only when the bench asks
    task automatic wr(input logic [15:0] a, input logic [15:0] d, output logic ack, output logic err);
        @(posedge i_clk);
        #1;
        o_addr  = a;
        o_wdata = d;
        o_wr_en = 1'b1;
        @(posedge i_clk);
        #1;
        ack = i_ack;
        err = i_err;
        release_bus();
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic [1:0] hs, output logic [1:0] cls);
        @(posedge i_clk);
        #1;
        o_addr  = a;
        o_rd_en = 1'b1;
        #1;
        cls = {i_monitor_rd, i_broadcast_rd};
        @(posedge i_clk);
        #1;
        d  = i_rdata;
        hs = {i_ack, i_rd_valid};
        release_bus();
    endtask
endmodule

// file: tb/scrb_bank_tb.sv
`timescale 1ns/1ps
module scrb_bank_tb;
    logic               i_clk, i_sys_rst, i_wr_en, i_rd_en, i_run_method_select;
    logic [15:0]        i_addr, i_wdata, o_rdata, o_speed_setpoint, o_vf_gain;
    logic [15:0]        o_analog_out_one, o_analog_out_two, o_pulse_train_out;
    logic signed [15:0] o_loop_setpoint;
    logic [7:0]         i_input_one_function, i_input_two_function;
    logic [1:0]         i_display_unit, o_speed_units;
    logic [6:0]         o_virtual_inputs;
    logic               o_rd_valid, o_ack, o_err, o_monitor_rd, o_broadcast_rd, o_fwd_run, o_rev_run;
    logic               o_serial_external_fault, o_fault_reset, o_serial_reference_select;
    logic               o_serial_control_select, o_relay_contact_terminals, o_optocoupler_out_one;
    logic               o_optocoupler_out_two, o_fault_contact_override, o_fault_contact_level;
    logic               o_pid_serial_select, o_input_terminal_five, o_input_terminal_six;
    logic               o_input_terminal_seven;
    int                 total_checks, miscompares, cycles;
    logic [15:0]        rw_addr [9] = '{16'h0001, 16'h0002, 16'h0003, 16'h0006, 16'h0007, 16'h0008,
                                        16'h0009, 16'h000a, 16'h000f};
    logic [15:0]        rw_mask [9] = '{16'h07ff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
                                        16'h00c7, 16'hffff, 16'h7002};
    logic [15:0]        bad_addr [11] = '{16'h0000, 16'h0004, 16'h0005, 16'h000b, 16'h000c, 16'h000d,
                                          16'h000e, 16'h0010, 16'h0020, 16'h003f, 16'h0040};

    scrb_bank dut (
        .i_clk, .i_sys_rst, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata, .o_rd_valid, .o_ack, .o_err,
        .o_monitor_rd, .o_broadcast_rd, .i_run_method_select, .i_input_one_function, .i_input_two_function,
        .i_display_unit, .o_fwd_run, .o_rev_run, .o_serial_external_fault, .o_fault_reset, .o_virtual_inputs,
        .o_serial_reference_select, .o_serial_control_select, .o_speed_setpoint, .o_speed_units, .o_vf_gain,
        .o_loop_setpoint, .o_analog_out_one, .o_analog_out_two, .o_relay_contact_terminals,
        .o_optocoupler_out_one, .o_optocoupler_out_two, .o_fault_contact_override, .o_fault_contact_level,
        .o_pulse_train_out, .o_pid_serial_select, .o_input_terminal_five, .o_input_terminal_six,
        .o_input_terminal_seven
    );

    scrb_master_model master (
        .i_clk, .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata), .i_rdata(o_rdata),
        .i_rd_valid(o_rd_valid), .i_ack(o_ack), .i_err(o_err), .i_monitor_rd(o_monitor_rd),
        .i_broadcast_rd(o_broadcast_rd)
    );

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr_chk(input logic [15:0] a, input logic [15:0] d, input logic ex_err);
        logic ack;
        logic err;
        master.wr(a, d, ack, err);
        chk("write handshake", {14'h0, ack, err}, {14'h0, ~ex_err, ex_err});
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic [1:0]  hs;
        logic [1:0]  cls;
        master.rd(a, d, hs, cls);
        chk("read data", d, exp);
        chk("read handshake", {14'h0, hs}, 16'h0003);
        chk("read class", {14'h0, cls}, {14'h0, a >= 16'h0020 && a <= 16'h003f, a > 16'h003f});
    endtask

    // Decoded outputs need a second edge after the write is taken
    task automatic settle();
        @(posedge i_clk);
        #1;
    endtask

    // Hang guard, well above the roughly 170 cycles the sequence needs
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        i_sys_rst = 1'b1;
        i_run_method_select = 1'b0;
        i_input_one_function = 8'h00;
        i_input_two_function = 8'h00;
        i_display_unit = 2'b10;
        repeat (12) @(posedge i_clk);
        #1;
        i_sys_rst = 1'b0;
        chk("idle outputs", {o_ack, o_err, o_rd_valid, o_fwd_run, o_virtual_inputs}, 16'h0000);
        for (int i = 0; i < 9; i++) begin
            rd_chk(rw_addr[i], 16'h0000);
            wr_chk(rw_addr[i], (rw_addr[i] == 16'h000a) ? 16'h7d00 : 16'hffff, 1'b0);
            rd_chk(rw_addr[i], (rw_addr[i] == 16'h000a) ? 16'h7d00 : rw_mask[i]);
        end
        for (int i = 0; i < 11; i++) begin
            wr_chk(bad_addr[i], 16'h1234, 1'b1);
            rd_chk(bad_addr[i], 16'h0000);
        end
        wr_chk(16'h000a, 16'h7d01, 1'b1);
        rd_chk(16'h000a, 16'h7d00);
        chk("pulse out", o_pulse_train_out, 16'h7d00);
        for (int m = 0; m < 2; m++) begin
            i_run_method_select = m[0];
            for (int b = 0; b < 4; b++) begin
                wr_chk(16'h0001, {14'h0, b[1:0]}, 1'b0);
                settle();
                chk("run", {14'h0, o_fwd_run, o_rev_run},
                    m ? {14'h0, b[0] & ~b[1], b[0] & b[1]} : {14'h0, b[0], b[1]});
            end
        end
        wr_chk(16'h0001, 16'h07fc, 1'b0);
        settle();
        chk("inputs", {4'h0, o_serial_external_fault, o_fault_reset, o_serial_reference_select,
            o_serial_control_select, 1'b0, o_virtual_inputs}, 16'h0c7f);
        i_input_one_function = 8'h28;
        i_input_two_function = 8'h2a;
        wr_chk(16'h0001, 16'h07fc, 1'b0);
        settle();
        chk("inputs alt", {4'h0, o_serial_external_fault, o_fault_reset, o_serial_reference_select,
            o_serial_control_select, 1'b0, o_virtual_inputs}, 16'h0f7c);
        wr_chk(16'h0002, 16'h1234, 1'b0);
        chk("speed", o_speed_setpoint, 16'h1234);
        chk("units", {14'h0, o_speed_units}, 16'h0002);
        wr_chk(16'h0003, 16'h0100, 1'b0);
        chk("gain", o_vf_gain, 16'h0100);
        wr_chk(16'h0006, 16'h8001, 1'b0);
        chk("loop", o_loop_setpoint, 16'h8001);
        wr_chk(16'h0007, 16'h4000, 1'b0);
        wr_chk(16'h0008, 16'h2000, 1'b0);
        chk("analog one", o_analog_out_one, 16'h4000);
        chk("analog two", o_analog_out_two, 16'h2000);
        wr_chk(16'h0009, 16'h0087, 1'b0);
        settle();
        chk("dout", {12'h0, o_relay_contact_terminals, o_optocoupler_out_one, o_optocoupler_out_two,
            o_fault_contact_override}, 16'h000e);
        chk("dout level", {15'h0, o_fault_contact_level}, 16'h0000);
        wr_chk(16'h0009, 16'h00c0, 1'b0);
        settle();
        chk("dout fault", {11'h0, o_relay_contact_terminals, o_optocoupler_out_one, o_optocoupler_out_two,
            o_fault_contact_override, o_fault_contact_level}, 16'h0003);
        wr_chk(16'h0009, 16'h0040, 1'b0);
        settle();
        chk("fault level", {14'h0, o_fault_contact_override, o_fault_contact_level}, 16'h0002);
        wr_chk(16'h000f, 16'h7002, 1'b0);
        settle();
        chk("select", {12'h0, o_pid_serial_select, o_input_terminal_five, o_input_terminal_six,
            o_input_terminal_seven}, 16'h000f);
        wr_chk(16'h000f, 16'h2000, 1'b0);
        settle();
        chk("select six", {12'h0, o_pid_serial_select, o_input_terminal_five, o_input_terminal_six,
            o_input_terminal_seven}, 16'h0002);
        conclude();
    end
endmodule
